// file: include/dlcr_pkg.sv
// shared constants for the line control register bank
package dlcr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRIMARY = 8'h10;
  localparam logic [7:0] IDX_SECONDARY = 8'h11;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h12;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h13;
  localparam logic [7:0] IDX_LINE_STATUS = 8'h14;
  // reset values
  localparam logic [7:0] PRIMARY_RST = 8'h08;
  localparam logic [7:0] SECONDARY_RST = 8'h00;
  // primary fields
  localparam int P_OFF_SQL = 7;
  localparam int P_OHS = 6;
  localparam int P_ACT = 5;
  localparam int P_RSVD = 4;
  localparam int P_DCT_LO = 2;
  localparam int P_RZ = 1;
  localparam int P_RT = 0;
  localparam logic [7:0] PRIMARY_WMASK = 8'hEF;
  // secondary fields
  localparam int S_MANUAL_CALIBRATE = 6;
  localparam int S_AUTOCAL_DISABLE = 5;
  localparam int S_LIM = 4;
  localparam int S_OPE = 3;
  localparam int S_BTE = 2;
  localparam int S_ROV = 1;
  localparam int S_BTD = 0;
  localparam logic [7:0] SECONDARY_WMASK = 8'h7F;
  // interrupt status bits
  localparam int I_CAL_DONE = 0;
  localparam int I_OVERLOAD = 1;
  localparam int I_BILLING = 2;
  localparam int I_RX_OVL = 3;
  localparam int IRQ_W = 4;
  // dc termination modes
  localparam logic [1:0] DCT_LOW_V = 2'h0;
  localparam logic [1:0] DCT_JAPAN = 2'h1;
  localparam logic [1:0] DCT_FCC = 2'h2;
  localparam logic [1:0] DCT_CTR21 = 2'h3;
  localparam logic [3:0] LOOP_MAX = 4'hF;
  // on-hook counter lengths in sample periods; calibration length in clock cycles
  localparam int ONHOOK_FAST_FS = 1024;
  localparam int ONHOOK_SLOW_FS = 4096;
  localparam int CAL_CYCLES = 256;
endpackage : dlcr_pkg

// file: src/dlcr_regs.sv
// line control register bank with apb slave, hook sequencing and irq
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps

module dlcr_regs #(
  parameter int FAST_FS = dlcr_pkg::ONHOOK_FAST_FS,
  parameter int SLOW_FS = dlcr_pkg::ONHOOK_SLOW_FS,
  parameter int CAL_LEN = dlcr_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line side inputs
  input wire logic hook_request,
  input wire logic fs_tick,
  input wire logic [3:0] loop_current_level,
  input wire logic billing_tone_seen,
  input wire logic rx_overload_seen,
  // line side controls
  output logic line_offhook,
  output logic onhook_ramp,
  output logic dc_term_disable,
  output logic dct_pin_reduced,
  output logic hookswitch_reduced,
  output logic ring_squelch_en,
  output logic ac_termination_choice,
  output logic [1:0] dc_termination_mode,
  output logic current_clamp_active,
  output logic ringer_impedance_sel,
  output logic ring_threshold_sel,
  output logic cal_busy,
  // interrupt
  output logic irq
);
  typedef enum logic [1:0] {ST_ONHOOK, ST_OFFHOOK, ST_RAMP} dlcr_hook_t;
  // status and mask width follows the package event count
  localparam int IRQ_W_L = dlcr_pkg::IRQ_W;

  dlcr_hook_t hook_st, next_hook_st;
  logic [7:0] primary, next_primary;
  logic [7:0] secondary, next_secondary;
  logic [IRQ_W_L-1:0] irq_status, next_irq_status;
  logic [IRQ_W_L-1:0] irq_mask, next_irq_mask;
  logic [12:0] ramp_cnt, next_ramp_cnt;
  logic [15:0] cal_cnt, next_cal_cnt;
  logic overload_trip, next_overload_trip;
  logic billing_trip, next_billing_trip;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic next_line_offhook, next_onhook_ramp, next_dc_term_disable;
  logic next_ring_squelch_en, next_clamp, next_cal_busy;

  // apb decode: write commits at the access edge that carries pready
  logic wr_en, setup;
  logic [7:0] idx;
  logic hit;
  always_comb begin
    setup = psel & ~penable;
    idx = {2'h0, paddr[7:2]};
    hit = (idx >= dlcr_pkg::IDX_PRIMARY) &&
          (idx <= dlcr_pkg::IDX_LINE_STATUS) && (paddr[1:0] == 2'h0);
    // a refused access must leave every register untouched
    wr_en = psel & penable & pready & pwrite & hit;
  end

  // register file, flags and interrupt status
  always_comb begin
    logic [7:0] wd;
    logic cal_start;
    logic [IRQ_W_L-1:0] ev;
    wd = pwdata[7:0];
    cal_start = 1'b0;
    ev = '0;
    next_primary = primary;
    next_secondary = secondary;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (wr_en && idx == dlcr_pkg::IDX_PRIMARY) begin
      // reserved bit 4 is never stored so it reads zero
      next_primary = wd & dlcr_pkg::PRIMARY_WMASK;
    end
    if (wr_en && idx == dlcr_pkg::IDX_SECONDARY) begin
      next_secondary = wd & dlcr_pkg::SECONDARY_WMASK;
      // of the writes, only a fresh 0 to 1 write of the bit starts a calibration
      cal_start = wd[dlcr_pkg::S_MANUAL_CALIBRATE] &
                  ~secondary[dlcr_pkg::S_MANUAL_CALIBRATE];
    end
    if (wr_en && idx == dlcr_pkg::IDX_IRQ_MASK) begin
      next_irq_mask = wd[IRQ_W_L-1:0];
    end
    // line events set the flag bits; setting beats a same-cycle write
    if (rx_overload_seen) begin
      next_secondary[dlcr_pkg::S_ROV] = 1'b1;
    end
    if (billing_tone_seen) begin
      next_secondary[dlcr_pkg::S_BTD] = 1'b1;
    end
    // auto calibration on going off-hook unless disabled
    if (hook_st == ST_ONHOOK && hook_request &&
        !secondary[dlcr_pkg::S_AUTOCAL_DISABLE]) begin
      cal_start = 1'b1;
    end
    // calibration timer
    // a start while busy reloads the timer and restarts the run
    next_cal_busy = cal_busy;
    next_cal_cnt = cal_cnt;
    if (cal_start) begin
      next_cal_busy = 1'b1;
      next_cal_cnt = 16'(CAL_LEN - 1);
    end else if (cal_busy) begin
      if (cal_cnt == 16'h0000) begin
        next_cal_busy = 1'b0;
        ev[dlcr_pkg::I_CAL_DONE] = 1'b1;
      end else begin
        next_cal_cnt = cal_cnt - 16'h0001;
      end
    end
    // overload trip holds until protection is written back to zero
    next_overload_trip = overload_trip;
    if (!secondary[dlcr_pkg::S_OPE]) begin
      next_overload_trip = 1'b0;
    end else if (line_offhook &&
                 loop_current_level == dlcr_pkg::LOOP_MAX) begin
      next_overload_trip = 1'b1;
      ev[dlcr_pkg::I_OVERLOAD] = ~overload_trip;
    end
    // billing tone protection while off-hook
    next_billing_trip = line_offhook & secondary[dlcr_pkg::S_BTE] &
                        secondary[dlcr_pkg::S_BTD];
    ev[dlcr_pkg::I_BILLING] = billing_tone_seen &
                              ~secondary[dlcr_pkg::S_BTD];
    ev[dlcr_pkg::I_RX_OVL] = rx_overload_seen &
                             ~secondary[dlcr_pkg::S_ROV];
    if (wr_en && idx == dlcr_pkg::IDX_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wd[IRQ_W_L-1:0];
    end
    next_irq_status = next_irq_status | ev;
    // irq follows the values being stored, so a clear never lags a cycle
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // hook sequencer: going on-hook waits out the on-hook counter
  always_comb begin
    next_hook_st = hook_st;
    next_ramp_cnt = ramp_cnt;
    case (hook_st)
      ST_ONHOOK: begin
        if (hook_request) begin
          next_hook_st = ST_OFFHOOK;
        end
      end
      ST_OFFHOOK: begin
        if (!hook_request) begin
          next_hook_st = ST_RAMP;
          // length latched here; a later speed change does not stretch it
          next_ramp_cnt = primary[dlcr_pkg::P_OHS] ?
                          13'(SLOW_FS - 1) : 13'(FAST_FS - 1);
        end
      end
      ST_RAMP: begin
        // a new off-hook request during the ramp aborts it at once
        if (hook_request) begin
          next_hook_st = ST_OFFHOOK;
        end else if (fs_tick) begin
          if (ramp_cnt == 13'h0000) begin
            next_hook_st = ST_ONHOOK;
          end else begin
            next_ramp_cnt = ramp_cnt - 13'h0001;
          end
        end
      end
      default: begin
        next_hook_st = ST_ONHOOK;
      end
    endcase
    next_line_offhook = next_hook_st != ST_ONHOOK;
    next_onhook_ramp = next_hook_st == ST_RAMP;
  end

  // line controls derived from fields and hook state
  always_comb begin
    logic off_sql;
    off_sql = primary[dlcr_pkg::P_OFF_SQL];
    next_dc_term_disable = line_offhook &
                           (off_sql | overload_trip | billing_trip);
    // squelch matters only on-hook; host owns its timing
    next_ring_squelch_en = ~line_offhook & off_sql;
    next_clamp = secondary[dlcr_pkg::S_LIM] &
                 (primary[3:2] == dlcr_pkg::DCT_CTR21);
  end

  // read mux, prepared in the setup cycle for the access cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = setup;
    if (setup) begin
      next_pslverr = ~hit;
      // refused addresses read as zero beside the error flag
      case (hit ? idx : 8'h00)
        dlcr_pkg::IDX_PRIMARY: next_prdata[7:0] = primary;
        dlcr_pkg::IDX_SECONDARY: next_prdata[7:0] = secondary;
        dlcr_pkg::IDX_IRQ_STATUS: next_prdata[3:0] = irq_status;
        dlcr_pkg::IDX_IRQ_MASK: next_prdata[3:0] = irq_mask;
        dlcr_pkg::IDX_LINE_STATUS: begin
          next_prdata[3:0] = {overload_trip, cal_busy, onhook_ramp,
                              line_offhook};
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  // reset is synchronous, so every reset branch holds constants only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      primary <= dlcr_pkg::PRIMARY_RST;
      secondary <= dlcr_pkg::SECONDARY_RST;
      irq_status <= '0;
      irq_mask <= '0;
      hook_st <= ST_ONHOOK;
      ramp_cnt <= 13'h0000;
      cal_cnt <= 16'h0000;
      cal_busy <= 1'b0;
      overload_trip <= 1'b0;
      billing_trip <= 1'b0;
      line_offhook <= 1'b0;
      onhook_ramp <= 1'b0;
      dc_term_disable <= 1'b0;
      ring_squelch_en <= 1'b0;
      current_clamp_active <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      primary <= next_primary;
      secondary <= next_secondary;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      hook_st <= next_hook_st;
      ramp_cnt <= next_ramp_cnt;
      cal_cnt <= next_cal_cnt;
      cal_busy <= next_cal_busy;
      overload_trip <= next_overload_trip;
      billing_trip <= next_billing_trip;
      line_offhook <= next_line_offhook;
      onhook_ramp <= next_onhook_ramp;
      dc_term_disable <= next_dc_term_disable;
      ring_squelch_en <= next_ring_squelch_en;
      current_clamp_active <= next_clamp;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // field copies registered so outputs come straight from flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dct_pin_reduced <= 1'b0;
      hookswitch_reduced <= 1'b0;
      ac_termination_choice <= 1'b0;
      // fcc mode here agrees with the primary register's reset value
      dc_termination_mode <= dlcr_pkg::DCT_FCC;
      ringer_impedance_sel <= 1'b0;
      ring_threshold_sel <= 1'b0;
    end else begin
      dct_pin_reduced <= next_dc_term_disable;
      hookswitch_reduced <= line_offhook & overload_trip;
      ac_termination_choice <= primary[dlcr_pkg::P_ACT];
      dc_termination_mode <= primary[3:2];
      ringer_impedance_sel <= primary[dlcr_pkg::P_RZ];
      ring_threshold_sel <= primary[dlcr_pkg::P_RT];
    end
  end
endmodule : dlcr_regs

// file: tb/dlcr_line_model.sv
// line side stand-in: sample tick and loop current
`timescale 1ns/10ps
module dlcr_line_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // bench command: force maximum loop current
  input wire logic ovl,
  // toward the block
  output logic fs_tick,
  output logic [3:0] loop_lvl,
  output logic bill,
  output logic rxo
);
  logic [1:0] div;
  logic [1:0] next_div;
  // tick every third clock so ticks never line up with bus phases
  always_comb begin
    next_div = (div == 2'h2) ? 2'h0 : div + 2'h1;
  end
  always_ff @(posedge ref_clk) begin
    div <= sys_rst ? 2'h0 : next_div;
  end
  assign fs_tick = (div == 2'h2);
  // current wanders below maximum unless an overload is commanded
  assign loop_lvl = ovl ? 4'hF : {2'h0, div};
  assign bill = 1'h0;
  assign rxo = 1'h0;
endmodule : dlcr_line_model

// file: tb/dlcr_regs_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module dlcr_regs_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // line
  input wire logic line_offhook,
  input wire logic onhook_ramp,
  input wire logic dc_term_disable,
  input wire logic dct_pin_reduced,
  input wire logic ring_squelch_en,
  input wire logic [1:0] dc_termination_mode,
  input wire logic current_clamp_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_rdy_next: assert property (s_setup |=> s_access)
    else $error("ready missing after setup");
  a_rdy_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_map: assert property (
    (s_access and paddr > 8'h50) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_align: assert property (
    (s_access and paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unaligned access not refused");
  a_clamp_mode: assert property (current_clamp_active |->
    dc_termination_mode == 2'h3 || $past(dc_termination_mode) == 2'h3)
    else $error("clamp outside ctr21 mode");
  a_dct_follow: assert property (dct_pin_reduced == dc_term_disable)
    else $error("pin voltage not reduced");
  a_sq_offhook: assert property (line_offhook[*2] |-> !ring_squelch_en)
    else $error("squelch active off-hook");
  a_ramp_held: assert property (onhook_ramp |-> line_offhook)
    else $error("ramp without line held");
endmodule : dlcr_regs_assertions

bind dlcr_regs dlcr_regs_assertions u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .line_offhook(line_offhook), .onhook_ramp(onhook_ramp),
  .dc_term_disable(dc_term_disable), .dct_pin_reduced(dct_pin_reduced),
  .ring_squelch_en(ring_squelch_en),
  .dc_termination_mode(dc_termination_mode),
  .current_clamp_active(current_clamp_active));

// file: tb/tb_dlcr_regs.sv
// self-checking bench for the line control register bank
`timescale 1ns/10ps
module tb_dlcr_regs;
  logic ref_clk, sys_rst, psel, penable, pwrite, hook_request, ovl;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, fs_tick, bill, rxo, irq, cal_busy;
  logic [3:0] loop_lvl;
  logic line_offhook, onhook_ramp, dc_term_disable, dct_pin_reduced;
  logic hookswitch_reduced, ring_squelch_en, ac_termination_choice;
  logic current_clamp_active, ringer_impedance_sel, ring_threshold_sel;
  logic [1:0] dc_termination_mode;
  logic [32:0] expq[$];
  int mismatches, num_checks, n;
  // short counts keep the ramp and calibration waits brief
  dlcr_regs #(.FAST_FS(4), .SLOW_FS(8), .CAL_LEN(4)) u_dlcr_regs (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hook_request(hook_request),
    .fs_tick(fs_tick), .loop_current_level(loop_lvl),
    .billing_tone_seen(bill), .rx_overload_seen(rxo),
    .line_offhook(line_offhook), .onhook_ramp(onhook_ramp),
    .dc_term_disable(dc_term_disable), .dct_pin_reduced(dct_pin_reduced),
    .hookswitch_reduced(hookswitch_reduced),
    .ring_squelch_en(ring_squelch_en),
    .ac_termination_choice(ac_termination_choice),
    .dc_termination_mode(dc_termination_mode),
    .current_clamp_active(current_clamp_active),
    .ringer_impedance_sel(ringer_impedance_sel),
    .ring_threshold_sel(ring_threshold_sel), .cal_busy(cal_busy), .irq(irq));
  dlcr_line_model u_dlcr_line_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ovl(ovl), .fs_tick(fs_tick), .loop_lvl(loop_lvl), .bill(bill),
    .rxo(rxo));
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    // one idle edge so the next call never re-drives psel in this step
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({a > 8'h50 || a < 8'h40 || a[1:0] != 2'h0, 24'h0, e});
    apb(1'h0, a, 8'h00);
  endtask : rd
  // bounded wait for a level, sampled mid-cycle where outputs are settled
  task automatic wt(ref logic s, input logic e);
    int k;
    k = 0;
    @(negedge ref_clk);
    while (s !== e && k < 12) begin
      @(negedge ref_clk);
      k++;
    end
    chk({32'h0, s}, {32'h0, e});
    @(posedge ref_clk);
  endtask : wt
  // read results are compared as they appear on the bus
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    void'($urandom(32'hDF75));
    {sys_rst, psel, penable, pwrite, hook_request, ovl} = 6'h20;
    {paddr, pwdata, mismatches, num_checks} = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(8'h40, 8'h08);
    rd(8'h44, 8'h00);
    rd(8'h60, 8'h00);
    rd(8'h41, 8'h00);
    apb(1'h1, 8'h41, 8'h00);
    rd(8'h40, 8'h08);
    apb(1'h1, 8'h44, 8'hFF);
    wt(cal_busy, 1'h1);
    rd(8'h44, 8'h7F);
    wt(cal_busy, 1'h0);
    chk({32'h0, irq}, 33'h0);
    apb(1'h1, 8'h44, 8'h10);
    for (int m = 0; m < 4; m++) begin
      v = 8'($urandom) & 8'h63 | 8'(m << 2);
      apb(1'h1, 8'h40, v);
      rd(8'h40, v);
      chk({28'h0, ac_termination_choice, dc_termination_mode,
        ringer_impedance_sel, ring_threshold_sel},
        {28'h0, v[5], v[3:0]});
      chk({32'h0, current_clamp_active}, 33'(m == 3));
    end
    // squelch set on-hook, as caller id reception needs
    apb(1'h1, 8'h40, 8'h88);
    wt(ring_squelch_en, 1'h1);
    hook_request <= 1'h1;
    wt(dc_term_disable, 1'h1);
    wt(ring_squelch_en, 1'h0);
    apb(1'h1, 8'h40, 8'h08);
    wt(dc_term_disable, 1'h0);
    apb(1'h1, 8'h4C, 8'h02);
    ovl <= 1'h1;
    apb(1'h1, 8'h44, 8'h18);
    wt(hookswitch_reduced, 1'h1);
    wt(irq, 1'h1);
    rd(8'h48, 8'h03);
    ovl <= 1'h0;
    apb(1'h1, 8'h44, 8'h10);
    apb(1'h1, 8'h48, 8'h0F);
    rd(8'h48, 8'h00);
    wt(irq, 1'h0);
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, 8'h40, s ? 8'h48 : 8'h08);
      hook_request <= 1'h1;
      wt(line_offhook, 1'h1);
      hook_request <= 1'h0;
      n = 0;
      for (int c = 0; c < 100 && line_offhook; c++) begin
        @(posedge ref_clk);
        n += int'(fs_tick && onhook_ramp);
      end
      chk(33'(n), s ? 33'h8 : 33'h4);
    end
    finish_test();
  end
endmodule : tb_dlcr_regs
